// file: core/incsk_decode.sv
// opcode decoder for the two increment-and-skip instructions
`timescale 1ns/100ps
module incsk_decode (
	input  wire logic [15:0] instr,          // instruction word
	output logic             hit,            // one of the two opcodes
	output logic             is_nonzero,     // skip-if-nonzero variant
	output logic             dest_file,      // write back to file
	output logic             bank_ptr_mode,  // bank pointer addressing
	output logic [7:0]       file_addr       // file operand
);
	wire [5:0] opc = instr[incsk_pkg::OPC_HI:incsk_pkg::OPC_LO];
	assign is_nonzero    = (opc == incsk_pkg::OPC_SKIP_NONZERO);                 // RL2
	assign hit           = (opc == incsk_pkg::OPC_SKIP_ZERO) || is_nonzero;      // RL1
	assign dest_file     = instr[incsk_pkg::DEST_BIT];                           // RL3
	assign bank_ptr_mode = instr[incsk_pkg::BANK_BIT];                           // RL3
	assign file_addr     = instr[7:0];                                           // RL3
endmodule : incsk_decode

// file: core/incsk_exec.sv
// execute logic for the increment-and-skip instructions
//
// Operation
// [RL1] The skip-if-zero opcode is six fixed upper bits, a destination bit, a bank bit, an 8-bit file address.
// [RL2] The skip-if-nonzero opcode has the same layout with its own six fixed upper bits.
// [RL3] The file operand spans 0..255 in a bank, destination and bank selectors are one bit each.
// [RL4] Skip-if-nonzero squashes the prefetched instruction on a nonzero result, taking two cycles.
// [RL5] Decode in Q1, read the file in Q2, increment in Q3, write the destination in Q4.
// [RL6] Destination bit 0 writes the accumulator, 1 writes back to the file register.
// [RL7] Bank bit 0 uses the access bank, 1 uses the bank pointer to pick the bank.
// [RL8] With the extended set on, bank bit 0 and operand at most 95 use indexed literal offset.
// [RL9] Skip-if-zero squashes on zero; skipping a two-word instruction takes three cycles; no flags change.
`timescale 1ns/100ps
module incsk_exec (
	input  wire logic        clk,             // 10 MHz core clock
	input  wire logic        arst_n,          // async reset, active low
	input  wire logic [15:0] instr,           // instruction word, held for the cycle
	input  wire logic        instr_valid,     // instruction present at Q1
	input  wire logic        next_two_word,   // prefetched instruction is two words
	input  wire logic        ext_set_en,      // extended instruction set enabled
	input  wire logic [3:0]  bank_pointer,    // bank pointer register
	input  wire logic [11:0] index_base,      // index register for literal offset
	input  wire logic [7:0]  file_rd_data,    // file read data
	output logic             q1_q,            // phase marker: start of cycle
	output logic             file_rd_q,       // file read strobe
	output logic [11:0]      file_addr_q,     // full data address
	output logic             file_wr_q,       // file write strobe
	output logic             acc_wr_q,        // accumulator write strobe
	output logic [7:0]       result_q,        // incremented value
	output logic             squash_q,        // prefetched word replaced by idle
	output logic             busy_q,          // instruction in flight
	output logic             status_wr_q      // status flag write, never set here
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic       hit, is_nz, dest_file, bank_mode;
	logic [7:0] f_addr;
	incsk_decode u_dec (
		.instr         (instr),
		.hit           (hit),
		.is_nonzero    (is_nz),
		.dest_file     (dest_file),
		.bank_ptr_mode (bank_mode),
		.file_addr     (f_addr)
	);

	incsk_pkg::incsk_phase_t phase_q, phase_d;
	incsk_pkg::incsk_op_t    op_q;
	logic        active_q, dest_q;
	logic [7:0]  data_q;
	logic [1:0]  squash_cnt_q;
	logic [11:0] addr_d;
	logic [7:0]  inc_val;
	logic        do_skip;

	wire indexed  = ext_set_en && !bank_mode && (f_addr <= incsk_pkg::INDEXED_LIMIT); // RL8
	wire acc_high = f_addr >= incsk_pkg::ACCESS_HI_BASE;
	always_comb begin
		if (bank_mode)
			addr_d = {bank_pointer, f_addr};                                        // RL7
		else if (indexed)
			addr_d = index_base + {4'h0, f_addr};                                   // RL8
		else if (acc_high)
			addr_d = {incsk_pkg::ACCESS_HI_BANK, f_addr};                           // RL7
		else
			addr_d = {incsk_pkg::ACCESS_LO_BANK, f_addr};                           // RL7
	end

	assign inc_val = data_q + incsk_pkg::ONE;
	assign do_skip = (op_q == incsk_pkg::OP_SKIP_NONZERO) ? (inc_val != incsk_pkg::ZERO) // RL4
	                                                      : (inc_val == incsk_pkg::ZERO); // RL9
	wire start = (phase_q == incsk_pkg::Q1) && instr_valid && hit && squash_cnt_q == 2'h0;

	always_comb begin
		case (phase_q)
			incsk_pkg::Q1: phase_d = incsk_pkg::Q2;
			incsk_pkg::Q2: phase_d = incsk_pkg::Q3;
			incsk_pkg::Q3: phase_d = incsk_pkg::Q4;
			default:       phase_d = incsk_pkg::Q1;
		endcase
	end

	// ----------------------------------------------------------------
	// four-phase sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q      <= incsk_pkg::Q1;
			op_q         <= incsk_pkg::OP_SKIP_ZERO;
			active_q     <= 1'b0;
			dest_q       <= 1'b0;
			data_q       <= incsk_pkg::ZERO;
			squash_cnt_q <= 2'h0;
			q1_q         <= 1'b0;
			file_rd_q    <= 1'b0;
			file_addr_q  <= 12'h000;
			file_wr_q    <= 1'b0;
			acc_wr_q     <= 1'b0;
			result_q     <= incsk_pkg::ZERO;
			squash_q     <= 1'b0;
			busy_q       <= 1'b0;
			status_wr_q  <= 1'b0;
		end else begin
			phase_q     <= phase_d;
			q1_q        <= (phase_d == incsk_pkg::Q1);
			file_rd_q   <= 1'b0;
			file_wr_q   <= 1'b0;
			acc_wr_q    <= 1'b0;
			status_wr_q <= 1'b0;                                                    // RL9
			if (start) begin                                                        // RL5
				active_q    <= 1'b1;
				op_q        <= is_nz ? incsk_pkg::OP_SKIP_NONZERO : incsk_pkg::OP_SKIP_ZERO;
				dest_q      <= dest_file;
				file_addr_q <= addr_d;
				file_rd_q   <= 1'b1;                                                // RL5
				busy_q      <= 1'b1;
			end
			if (active_q && phase_q == incsk_pkg::Q2)
				data_q <= file_rd_data;                                             // RL5
			if (active_q && phase_q == incsk_pkg::Q3)
				result_q <= inc_val;                                                // RL5
			if (active_q && phase_q == incsk_pkg::Q3) begin
				file_wr_q <= dest_q;                                                // RL6
				acc_wr_q  <= !dest_q;                                               // RL6
			end
			if (active_q && phase_q == incsk_pkg::Q4) begin
				active_q <= 1'b0;
				if (do_skip)
					squash_cnt_q <= next_two_word ? incsk_pkg::SQUASH_TWO
					                              : incsk_pkg::SQUASH_ONE;          // RL9
			end else if (phase_q == incsk_pkg::Q4 && squash_cnt_q != 2'h0)
				squash_cnt_q <= squash_cnt_q - 2'h1;
			if (phase_q == incsk_pkg::Q4) begin
				squash_q <= active_q ? do_skip : (squash_cnt_q > 2'h1);             // RL4
				busy_q   <= active_q ? do_skip : (squash_cnt_q > 2'h1);
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_wr_q4;
		@(posedge clk) disable iff (!arst_n) file_wr_q |-> phase_q == incsk_pkg::Q4;
	endproperty
	a_wr_q4: assert property (p_wr_q4) else $error("write outside q4"); // RL5
	property p_rd_q2;
		@(posedge clk) disable iff (!arst_n) file_rd_q |-> phase_q == incsk_pkg::Q2;
	endproperty
	a_rd_q2: assert property (p_rd_q2) else $error("read outside q2"); // RL5
	property p_one_dest;
		@(posedge clk) disable iff (!arst_n) !(file_wr_q && acc_wr_q);
	endproperty
	a_one_dest: assert property (p_one_dest) else $error("two destinations"); // RL6
	property p_dest_sel;
		@(posedge clk) disable iff (!arst_n) start |-> ##3 (file_wr_q == $past(dest_file, 3));
	endproperty
	a_dest_sel: assert property (p_dest_sel) else $error("wrong destination"); // RL6
	property p_inc;
		@(posedge clk) disable iff (!arst_n)
			(active_q && phase_q == incsk_pkg::Q3) |=> result_q == $past(data_q) + incsk_pkg::ONE;
	endproperty
	a_inc: assert property (p_inc) else $error("bad increment"); // RL5
	property p_nz_skip;
		@(posedge clk) disable iff (!arst_n)
			(start && is_nz) ##3 (result_q != incsk_pkg::ZERO) |=> squash_q;
	endproperty
	a_nz_skip: assert property (p_nz_skip) else $error("nonzero skip missed"); // RL4
	property p_z_skip;
		@(posedge clk) disable iff (!arst_n)
			(start && !is_nz) ##3 (result_q == incsk_pkg::ZERO) |=> squash_q;
	endproperty
	a_z_skip: assert property (p_z_skip) else $error("zero skip missed"); // RL9
	property p_no_flags;
		@(posedge clk) disable iff (!arst_n) !status_wr_q;
	endproperty
	a_no_flags: assert property (p_no_flags) else $error("status changed"); // RL9
	property p_bank;
		@(posedge clk) disable iff (!arst_n)
			(start && bank_mode) |=> file_addr_q == {$past(bank_pointer), $past(f_addr)};
	endproperty
	a_bank: assert property (p_bank) else $error("bank address wrong"); // RL7
	property p_decode;
		@(posedge clk) disable iff (!arst_n)
			start |-> (instr[15:10] == incsk_pkg::OPC_SKIP_ZERO
			        || instr[15:10] == incsk_pkg::OPC_SKIP_NONZERO);
	endproperty
	a_decode: assert property (p_decode) else $error("bad decode"); // RL1
endmodule : incsk_exec

// file: core/incsk_pkg.sv
// constants for the increment-and-skip execute block
package incsk_pkg;
	localparam logic [5:0] OPC_SKIP_ZERO    = 6'h0F;  // 0011 11
	localparam logic [5:0] OPC_SKIP_NONZERO = 6'h12;  // 0100 10
	localparam int         OPC_HI           = 15;
	localparam int         OPC_LO           = 10;
	localparam int         DEST_BIT         = 9;
	localparam int         BANK_BIT         = 8;
	localparam logic [7:0] INDEXED_LIMIT    = 8'h5F;
	localparam logic [7:0] ACCESS_HI_BASE   = 8'h60;
	localparam logic [3:0] ACCESS_HI_BANK   = 4'hF;
	localparam logic [3:0] ACCESS_LO_BANK   = 4'h0;
	localparam logic [7:0] ONE              = 8'h01;
	localparam logic [7:0] ZERO             = 8'h00;
	localparam logic [1:0] SQUASH_ONE       = 2'h1;
	localparam logic [1:0] SQUASH_TWO       = 2'h2;
	typedef enum logic [1:0] {Q1, Q2, Q3, Q4} incsk_phase_t;
	typedef enum logic {OP_SKIP_ZERO, OP_SKIP_NONZERO} incsk_op_t;
endpackage : incsk_pkg

// file: verification/increment_skip_instructions_test.sv
// self-checking bench for the increment-and-skip execute block
`timescale 1ns/100ps
module increment_skip_instructions_test;
	// ----------------
	// signals
	// ----------------
	logic        clk, arst_n, instr_valid, next_two_word, ext_set_en;
	logic [15:0] instr;
	logic [3:0]  bank_pointer;
	logic [11:0] index_base, file_addr_q;
	logic [7:0]  file_rd_data, result_q;
	logic        q1_q, file_rd_q, file_wr_q, acc_wr_q, squash_q, busy_q, status_wr_q;
	int          failures, check_count, cycles;
	incsk_exec incsk_exec_i (.clk, .arst_n, .instr, .instr_valid, .next_two_word, .ext_set_en,
		.bank_pointer, .index_base, .file_rd_data, .q1_q, .file_rd_q, .file_addr_q,
		.file_wr_q, .acc_wr_q, .result_q, .squash_q, .busy_q, .status_wr_q);
	incsk_file_model incsk_file_model_i (.clk, .arst_n, .file_rd_q, .file_addr_q,
		.file_rd_data);
	// ----------------
	// clock and limit
	// ----------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			finish_test();
		end
	end
	// ----------------
	// tasks
	// ----------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	// inputs held one cycle, or two on a skip so the idle cycle must refuse them
	task automatic run(input logic [15:0] w, input logic [3:0] bk, input logic ext,
		input logic [11:0] base, input logic tw, input logic hit, input logic [11:0] ea,
		input logic ef, input int esq);
		int rd, wf, wa, sq, st, qc, bz, n;
		logic [7:0] res;
		logic [11:0] ad;
		instr = w;
		instr_valid = 1'b1;
		bank_pointer = bk;
		ext_set_en = ext;
		index_base = base;
		next_two_word = tw;
		repeat (16) begin
			@(negedge clk);
			n++;
			if (n == (esq > 0 ? 8 : 4)) instr_valid = 1'b0;
			if (file_rd_q === 1'b1) begin
				rd++;
				ad = file_addr_q;
			end
			if (file_wr_q === 1'b1 || acc_wr_q === 1'b1) res = result_q;
			wf += (file_wr_q === 1'b1);
			wa += (acc_wr_q === 1'b1);
			sq += (squash_q === 1'b1);
			st += (status_wr_q !== 1'b0);
			qc += (q1_q === 1'b1);
			bz += (busy_q === 1'b1);
		end
		check("file read", rd, hit);
		check("file write", wf, hit & ef);
		check("acc write", wa, hit & !ef);
		check("squash", sq, esq);
		check("status write", st, 0);
		check("phase marks", qc, 4);
		check("busy", bz, (hit ? 3 : 0) + esq);
		if (hit) begin
			check("address", ad, ea);
			check("result", res, 8'(~ea[7:0] + 8'h01));
		end
	endtask : run
	task automatic skip_zero_cases();
		run(16'h3F10, 4'h3, 1'b0, 12'h000, 1'b0, 1'b1, 12'h310, 1'b1, 0);
		run(16'h3C00, 4'h3, 1'b0, 12'h000, 1'b0, 1'b1, 12'h000, 1'b0, 4);
	endtask : skip_zero_cases
	task automatic skip_nonzero_cases();
		run(16'h4870, 4'h2, 1'b0, 12'h000, 1'b1, 1'b1, 12'hF70, 1'b0, 8);
		run(16'h4900, 4'h2, 1'b0, 12'h000, 1'b0, 1'b1, 12'h200, 1'b0, 0);
	endtask : skip_nonzero_cases
	task automatic indexed_boundary();
		run(16'h4A20, 4'h1, 1'b1, 12'h0DF, 1'b0, 1'b1, 12'h0FF, 1'b1, 4);
		run(16'h3C60, 4'h1, 1'b1, 12'h123, 1'b0, 1'b1, 12'hF60, 1'b0, 0);
		run(16'h3E5F, 4'h1, 1'b1, 12'h0A0, 1'b0, 1'b1, 12'h0FF, 1'b1, 0);
	endtask : indexed_boundary
	task automatic foreign_opcode();
		run(16'h2800, 4'h0, 1'b0, 12'h000, 1'b0, 1'b0, 12'h000, 1'b0, 0);
	endtask : foreign_opcode
	task automatic reset_mid_run();
		instr = 16'h3C00;
		instr_valid = 1'b1;
		@(negedge clk);
		check("taken before reset", file_rd_q, 1'b1);
		arst_n = 1'b0;
		instr_valid = 1'b0;
		@(negedge clk);
		check("strobes in reset", {q1_q, file_rd_q, file_wr_q, acc_wr_q}, 4'h0);
		check("levels in reset", {squash_q, busy_q, status_wr_q}, 3'h0);
		check("data in reset", {file_addr_q, result_q}, 20'h00000);
		arst_n = 1'b1;
		run(16'h3C00, 4'h3, 1'b0, 12'h000, 1'b0, 1'b1, 12'h000, 1'b0, 4);
	endtask : reset_mid_run
	task automatic finish_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	// ----------------
	// sequence
	// ----------------
	initial begin
		arst_n = 1'b0;
		instr = 16'h0000;
		instr_valid = 1'b0;
		next_two_word = 1'b0;
		ext_set_en = 1'b0;
		bank_pointer = 4'h0;
		index_base = 12'h000;
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		skip_zero_cases();
		skip_nonzero_cases();
		indexed_boundary();
		foreign_opcode();
		reset_mid_run();
		finish_test();
	end
endmodule : increment_skip_instructions_test

// file: verification/incsk_file_model.sv
// file register model on the far side of the execute block
`timescale 1ns/100ps
module incsk_file_model (
	input  wire logic        clk,          // core clock
	input  wire logic        arst_n,       // async reset, active low
	input  wire logic        file_rd_q,    // read strobe
	input  wire logic [11:0] file_addr_q,  // data address
	output logic      [7:0]  file_rd_data  // read data
);
	// ----------------
	// read port
	// ----------------
	logic [7:0] idle_q;  // changes every clock, seen on the read data only while not read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			idle_q <= 8'h5A;
		else
			idle_q <= ~idle_q;
	end
	// contents are the inverse of the low address byte
	assign file_rd_data = file_rd_q ? ~file_addr_q[7:0] : idle_q;
endmodule : incsk_file_model
